// [src/sepc_defines.vh]
// constants for the serial eeprom command and protection block
`ifndef SEPC_DEFINES_VH
`define SEPC_DEFINES_VH
// opcodes
`define SEPC_OP_SET_LATCH 8'h06
`define SEPC_OP_CLR_LATCH 8'h04
`define SEPC_OP_STAT_RD 8'h05
`define SEPC_OP_STAT_WR 8'h01
`define SEPC_OP_MEM_RD 8'h03
`define SEPC_OP_MEM_WR 8'h02
`define SEPC_OP_ID_RD 8'h83
`define SEPC_OP_ID_WR 8'h82
// status byte field positions
`define SEPC_ST_LOCK 7
`define SEPC_ST_BP_HI 3
`define SEPC_ST_BP_LO 2
`define SEPC_ST_LATCH 1
`define SEPC_ST_BUSY 0
// protected range lower bounds
`define SEPC_PROT_QUARTER 15'h6000
`define SEPC_PROT_HALF 15'h4000
`define SEPC_PROT_WHOLE 15'h0000
// address decode for identification page commands
`define SEPC_ID_LOCK_ADDR 16'h0400
`define SEPC_ID_UPPER_MASK 16'hFFC0
// self-timed write cycle, in microseconds, and in clk_sys cycles at 100 MHz
`define SEPC_TW_US 5000
`define SEPC_CLK_MHZ 100
`define SEPC_TW_CYCLES (`SEPC_TW_US * `SEPC_CLK_MHZ)
// non-volatile status reset image
`define SEPC_NV_RESET 3'h0
`endif

// [src/sepc_fifo.v]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sepc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire flush,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrPtr_ff;
    reg [AW:0] rdPtr_ff;
    wire [AW:0] used;
    wire doWr;
    wire doRd;

    assign used = wrPtr_ff - rdPtr_ff;
    assign inReady = (used != DEPTH[AW:0]);
    assign outValid = (used != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_ff[AW-1:0]];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    // storage write
    always @(posedge clk_sys) begin
        if (doWr) begin
            mem[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    // pointers
    always @(posedge clk_sys) begin
        if (sys_rst || flush) begin
            wrPtr_ff <= {(AW+1){1'b0}};
            rdPtr_ff <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (doRd) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [src/sepc_sync.v]
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module sepc_sync #(
    parameter WIDTH = 4
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [WIDTH-1:0] pinIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_ff;

    // first stage read only by second stage; reset value is chip select idle high
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_ff <= {WIDTH{1'b1}};
            syncOut <= {WIDTH{1'b1}};
        end else begin
            meta_ff <= pinIn;
            syncOut <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// [src/sepc_top.v]
// serial eeprom instruction decoder, status byte and write protection
// Function
// R1 - memory or status write executes only if clock count is a multiple of eight
// R2 - master sends set-latch opcode before any modifying instruction
// R3 - block-protect field picks none, 6000h-7FFFh, 4000h-7FFFh or whole array
// R4 - lock bit set and protect pin low: status writes rejected, bits read-only
// R5 - instruction accepted only if deselect lands between final and next rising edge
// R6 - final bit is opcode or data byte end; reads skip the window check
// R7 - commands are whole bytes msb first, opcode first after select
// R8 - unknown opcode: ignore input until deselected
// R9 - opcodes 06h set latch, 04h clear latch, 05h status read
// R10 - opcodes 01h status write, 03h memory read, 02h memory write
// R11 - id page opcodes 83h read and 82h write, told apart by address
// R12 - memory address: two bytes, bit 15 ignored, bits 14..0 select byte; the first read address on rdAddr_ff keeps bit 15
// R13 - id page address upper ten bits zero; lock address has only bit 10
// R14 - after set-latch opcode wait for deselect; only way to set latch
// R15 - latch cleared at reset, clear-latch, status write or memory write completion
// R16 - status byte readable any time, repeated while selected
// R17 - master polls busy flag during a write cycle
// R18 - busy flag is 1 while a write cycle runs, else 0
// R19 - latch flag 0 rejects memory and status writes
// R20 - block-protect bits change only by status write outside locked mode
// R21 - status byte: lock, 0, 0, 0, bp hi, bp lo, latch, busy
// R22 - sample on rising link clock, drive on falling edge, both modes
// R23 - busy stays 1 for whole cycle; latch clears at its end
// R24 - memory read during a write cycle is not accepted
// R25 - rejected writes leave memory, status and busy unchanged; memory write data sent during a memory write cycle still reaches the array
// R26 - serial output released except while shifting read data
`timescale 1ns/10ps
`default_nettype none
`include "sepc_defines.vh"
module sepc_top #(
    parameter TW_CYCLES = `SEPC_TW_CYCLES,
    parameter FIFO_DEPTH = 8
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire linkClk,
    input wire selectN,
    input wire serIn,
    input wire protectN,
    output reg serOut_ff,
    output reg serOutEnN_ff,
    output reg [7:0] statusByte_ff,
    output reg hardwareLockedMode_ff,
    output reg wrValid_ff,
    output reg [14:0] wrAddr_ff,
    output reg [7:0] wrData_ff,
    output reg wrIdPage_ff,
    output reg wrIdLock_ff,
    input wire wrReady,
    output reg rdReq_ff,
    output reg [15:0] rdAddr_ff,
    output reg rdIdPage_ff,
    input wire rdValid,
    input wire [7:0] rdData
);
    // ************************************************************
    // pin synchronisation and edge detection
    // ************************************************************
    wire [3:0] syncPins;
    reg clkDly_ff;
    reg selDly_ff;
    wire clkS = syncPins[0];
    wire selS = syncPins[1];
    wire dinS = syncPins[2];
    wire wpS = syncPins[3];
    wire riseC = clkS && !clkDly_ff;
    wire fallC = !clkS && clkDly_ff;
    wire selFall = !selS && selDly_ff;
    wire selRise = selS && !selDly_ff;

    sepc_sync #(.WIDTH(4)) uSync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pinIn({protectN, serIn, selectN, linkClk}),
        .syncOut(syncPins)
    );

    // edge history of synchronised clock and select
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            clkDly_ff <= 1'b1;
            selDly_ff <= 1'b1;
        end else begin
            clkDly_ff <= clkS;
            selDly_ff <= selS;
        end
    end

    // ************************************************************
    // receive state
    // ************************************************************
    localparam ST_OPCODE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_DATA = 3'h2;
    localparam ST_READ = 3'h3;
    localparam ST_STATRD = 3'h4;
    localparam ST_WAIT = 3'h5;

    reg [2:0] state_ff;
    reg [7:0] shift_ff;
    reg [2:0] bitCnt_ff;
    reg [7:0] opcode_ff;
    reg [15:0] addr_ff;
    reg addrByte_ff;
    reg byteDone_ff;
    reg windowOpen_ff;
    reg lateEdge_ff;
    reg dataSeen_ff;
    reg [7:0] statData_ff;
    reg [7:0] outByte_ff;
    reg [2:0] outCnt_ff;
    reg latch_ff;
    reg busy_ff;
    reg [2:0] nv_ff;
    reg [31:0] twCnt_ff;
    reg pendStat_ff;
    reg [2:0] pendNv_ff;
    reg selected_ff;
    reg primed_ff;
    wire [7:0] nxtByte = {shift_ff[6:0], dinS};
    wire lastBit = (bitCnt_ff == 3'h7);
    wire hwLock = nv_ff[2] && !wpS;
    wire [14:0] protBase = (nv_ff[1:0] == 2'b01) ? `SEPC_PROT_QUARTER :
                           (nv_ff[1:0] == 2'b10) ? `SEPC_PROT_HALF : `SEPC_PROT_WHOLE;
    wire isProtected = (nv_ff[1:0] != 2'b00) && (addr_ff[14:0] >= protBase); // R3
    wire fifoInReady;
    wire fifoOutValid;
    wire [7:0] fifoOutData;
    wire fifoPush = riseC && lastBit && selected_ff && (state_ff == ST_DATA);
    wire commitOk = windowOpen_ff && !lateEdge_ff; // R5
    wire [7:0] curStat = {nv_ff[2], 3'h0, nv_ff[1:0], latch_ff, busy_ff}; // R21

    reg drain_ff;
    // write-data buffer between serial receive and the array port
    sepc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) uFifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .flush(selFall),
        .inValid(fifoPush && opcode_ff != `SEPC_OP_STAT_WR),
        .inReady(fifoInReady),
        .inData(nxtByte),
        .outValid(fifoOutValid),
        .outReady(drain_ff && wrReady),
        .outData(fifoOutData)
    );

    // input side: shift in on rising link clock edges while selected
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff <= ST_OPCODE;
            shift_ff <= 8'h00;
            bitCnt_ff <= 3'h0;
            opcode_ff <= 8'h00;
            addr_ff <= 16'h0000;
            addrByte_ff <= 1'b0;
            windowOpen_ff <= 1'b0;
            lateEdge_ff <= 1'b0;
            dataSeen_ff <= 1'b0;
            statData_ff <= 8'h00;
            selected_ff <= 1'b0;
            primed_ff <= 1'b0;
            rdReq_ff <= 1'b0;
            rdAddr_ff <= 16'h0000;
            rdIdPage_ff <= 1'b0;
        end else begin
            rdReq_ff <= 1'b0;
            if (selS) begin
                primed_ff <= 1'b1; // select needs a falling edge after reset
            end
            if (selFall && primed_ff) begin
                selected_ff <= 1'b1;
                state_ff <= ST_OPCODE; // R7
                bitCnt_ff <= 3'h0;
                addrByte_ff <= 1'b0;
                windowOpen_ff <= 1'b0;
                lateEdge_ff <= 1'b0;
                dataSeen_ff <= 1'b0;
            end else if (selRise) begin
                selected_ff <= 1'b0;
            end else if (selected_ff && riseC) begin
                shift_ff <= nxtByte; // R22
                bitCnt_ff <= bitCnt_ff + 3'h1;
                // any rising edge after a completed byte closes the window until the next byte ends
                windowOpen_ff <= lastBit; // R1
                lateEdge_ff <= 1'b0;
                case (state_ff)
                    ST_OPCODE: begin
                        if (lastBit) begin
                            opcode_ff <= nxtByte;
                            case (nxtByte)
                                `SEPC_OP_SET_LATCH, `SEPC_OP_CLR_LATCH: state_ff <= ST_WAIT; // R9
                                `SEPC_OP_STAT_RD: state_ff <= ST_STATRD; // R16
                                `SEPC_OP_STAT_WR: state_ff <= ST_DATA; // R10
                                `SEPC_OP_MEM_RD, `SEPC_OP_MEM_WR,
                                `SEPC_OP_ID_RD, `SEPC_OP_ID_WR: state_ff <= ST_ADDR; // R11
                                default: begin
                                    state_ff <= ST_WAIT; // R8
                                    opcode_ff <= 8'hFF;
                                end
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        if (lastBit) begin
                            addr_ff <= {addr_ff[7:0], nxtByte}; // R12
                            addrByte_ff <= 1'b1;
                            if (addrByte_ff) begin
                                if (opcode_ff == `SEPC_OP_MEM_RD || opcode_ff == `SEPC_OP_ID_RD) begin
                                    // R24
                                    state_ff <= busy_ff ? ST_WAIT : ST_READ;
                                    rdReq_ff <= !busy_ff;
                                    rdAddr_ff <= {addr_ff[7:0], nxtByte};
                                    rdIdPage_ff <= (opcode_ff == `SEPC_OP_ID_RD);
                                end else begin
                                    state_ff <= ST_DATA;
                                end
                            end
                        end
                    end
                    ST_DATA: begin
                        if (lastBit) begin
                            dataSeen_ff <= 1'b1;
                            statData_ff <= nxtByte;
                            if (!fifoInReady && opcode_ff != `SEPC_OP_STAT_WR) begin
                                state_ff <= ST_WAIT; // overrun drops the command
                                opcode_ff <= 8'hFF;
                            end
                        end
                    end
                    ST_READ: begin
                        if (lastBit) begin
                            rdReq_ff <= 1'b1; // sequential read, wraps in 15 bits
                            rdAddr_ff <= {1'b0, rdAddr_ff[14:0] + 15'h0001};
                        end
                    end
                    default: begin
                        // wait: further input ignored
                    end
                endcase
            end else if (selected_ff && fallC && !windowOpen_ff) begin
                lateEdge_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // commit on deselect, status register and write cycle
    // ************************************************************
    wire isMemWr = (opcode_ff == `SEPC_OP_MEM_WR) || (opcode_ff == `SEPC_OP_ID_WR);
    wire isStatWr = (opcode_ff == `SEPC_OP_STAT_WR);
    wire idAddrOk = ((addr_ff & `SEPC_ID_UPPER_MASK) == 16'h0000) || (addr_ff == `SEPC_ID_LOCK_ADDR); // R13
    wire endOk = selRise && selected_ff && commitOk && (bitCnt_ff == 3'h0) && dataSeen_ff; // R1
    wire doMemWr = endOk && (state_ff == ST_DATA) && isMemWr && latch_ff && !busy_ff && // R19
                   (opcode_ff == `SEPC_OP_ID_WR ? idAddrOk : !isProtected);
    wire doStatWr = endOk && (state_ff == ST_DATA) && isStatWr && latch_ff && !busy_ff && !hwLock; // R4
    wire doOpOnly = selRise && selected_ff && commitOk && (bitCnt_ff == 3'h0) && (state_ff == ST_WAIT); // R6

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            latch_ff <= 1'b0; // R15
            busy_ff <= 1'b0;
            nv_ff <= `SEPC_NV_RESET;
            twCnt_ff <= 32'h00000000;
            pendStat_ff <= 1'b0;
            pendNv_ff <= 3'h0;
            drain_ff <= 1'b0;
            wrValid_ff <= 1'b0;
            wrAddr_ff <= 15'h0000;
            wrData_ff <= 8'h00;
            wrIdPage_ff <= 1'b0;
            wrIdLock_ff <= 1'b0;
        end else begin
            wrValid_ff <= 1'b0;
            // rejected writes fall through and change nothing unless a memory write cycle is running, which drains their data too
            if (doMemWr || doStatWr) begin // R25
                busy_ff <= 1'b1; // R18
                twCnt_ff <= TW_CYCLES - 1;
                pendStat_ff <= doStatWr;
                pendNv_ff <= {statData_ff[`SEPC_ST_LOCK], statData_ff[`SEPC_ST_BP_HI], statData_ff[`SEPC_ST_BP_LO]};
                drain_ff <= doMemWr;
                wrAddr_ff <= {addr_ff[14:6], addr_ff[5:0] - 6'h01}; // R12
                wrIdPage_ff <= (opcode_ff == `SEPC_OP_ID_WR) && !addr_ff[10];
                wrIdLock_ff <= (opcode_ff == `SEPC_OP_ID_WR) && addr_ff[10];
            end else if (busy_ff) begin
                if (drain_ff && fifoOutValid && wrReady) begin
                    wrValid_ff <= 1'b1;
                    wrData_ff <= fifoOutData;
                    wrAddr_ff <= {wrAddr_ff[14:6], wrAddr_ff[5:0] + 6'h01};
                end
                if (twCnt_ff == 32'h00000000) begin
                    busy_ff <= 1'b0; // R23
                    latch_ff <= 1'b0; // R15
                    drain_ff <= 1'b0;
                    if (pendStat_ff) begin
                        nv_ff <= pendNv_ff; // R20
                    end
                end else begin
                    twCnt_ff <= twCnt_ff - 32'h00000001;
                end
            end
            if (doOpOnly && opcode_ff == `SEPC_OP_SET_LATCH) begin
                latch_ff <= 1'b1; // R14
            end else if (doOpOnly && opcode_ff == `SEPC_OP_CLR_LATCH) begin
                latch_ff <= 1'b0; // R15
            end
        end
    end

    // ************************************************************
    // serial output: load and drive on falling link edge
    // ************************************************************
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            serOut_ff <= 1'b0;
            serOutEnN_ff <= 1'b1;
            outByte_ff <= 8'h00;
            outCnt_ff <= 3'h0;
            statusByte_ff <= 8'h00;
            hardwareLockedMode_ff <= 1'b0;
        end else begin
            statusByte_ff <= curStat;
            hardwareLockedMode_ff <= hwLock;
            if (!selected_ff || selRise) begin
                serOutEnN_ff <= 1'b1; // R26
                outCnt_ff <= 3'h0;
            end else if (fallC && (state_ff == ST_STATRD || state_ff == ST_READ)) begin
                if (outCnt_ff == 3'h0) begin
                    // R16
                    serOut_ff <= (state_ff == ST_STATRD) ? curStat[7] : rdData[7];
                    outByte_ff <= (state_ff == ST_STATRD) ? {curStat[6:0], 1'b0} : {rdData[6:0], 1'b0};
                end else begin
                    serOut_ff <= outByte_ff[7];
                    outByte_ff <= {outByte_ff[6:0], 1'b0};
                end
                outCnt_ff <= outCnt_ff + 3'h1;
                serOutEnN_ff <= 1'b0; // R22
            end
        end
    end
endmodule
`default_nettype wire

// [sim/sepc_top_chk.sv]
// concurrent checks on the ports of the serial eeprom command block
`timescale 1ns/10ps
`default_nettype none
module sepc_top_chk #(
    parameter TW_CYCLES = 50,
    parameter FIFO_DEPTH = 8
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire selectN,
    input wire protectN,
    input wire serOutEnN_ff,
    input wire [7:0] statusByte_ff,
    input wire hardwareLockedMode_ff,
    input wire wrValid_ff,
    input wire [14:0] wrAddr_ff,
    input wire wrIdPage_ff,
    input wire wrIdLock_ff,
    input wire rdReq_ff
);
    // ****************************************
    // helper counter and properties
    // ****************************************
    logic [31:0] busyCnt_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // length of the current busy stretch
    always @(posedge clk_sys) begin
        if (sys_rst) busyCnt_ff <= 32'h0;
        else if (statusByte_ff[0]) busyCnt_ff <= busyCnt_ff + 32'h1;
        else busyCnt_ff <= 32'h0;
    end
    a_zero_bits: assert property (statusByte_ff[6:4] == 3'h0)
        else $error("status bits 6..4 not zero");
    a_oe_idle: assert property (selectN [*5] |-> serOutEnN_ff)
        else $error("serial output driven while deselected");
    a_hw_enter: assert property ((statusByte_ff[7] && !protectN) [*6] |-> hardwareLockedMode_ff)
        else $error("locked mode not entered");
    a_nv_frozen: assert property (hardwareLockedMode_ff && $past(hardwareLockedMode_ff) |-> $stable(statusByte_ff[7:2]))
        else $error("status bits changed in locked mode");
    a_wr_range: assert property (wrValid_ff && !wrIdPage_ff && !wrIdLock_ff |-> (statusByte_ff[3:2] == 2'h0)
        || (statusByte_ff[3:2] == 2'h1 && wrAddr_ff < 15'h6000)
        || (statusByte_ff[3:2] == 2'h2 && wrAddr_ff < 15'h4000))
        else $error("write into protected range");
    a_wr_busy: assert property ($rose(wrValid_ff) |-> ##[0:3] statusByte_ff[0])
        else $error("array write without busy flag");
    a_rd_idle: assert property (rdReq_ff |-> !statusByte_ff[0])
        else $error("read request during write cycle");
    a_latch_end: assert property ($fell(statusByte_ff[0]) |-> !statusByte_ff[1])
        else $error("latch still set after write cycle");
    a_busy_span: assert property ($fell(statusByte_ff[0]) |-> busyCnt_ff >= TW_CYCLES - 1
        && busyCnt_ff <= TW_CYCLES + 1)
        else $error("write cycle length wrong");
endmodule
bind sepc_top sepc_top_chk #(.TW_CYCLES(TW_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .selectN(selectN), .protectN(protectN), .serOutEnN_ff(serOutEnN_ff),
    .statusByte_ff(statusByte_ff), .hardwareLockedMode_ff(hardwareLockedMode_ff), .wrValid_ff(wrValid_ff),
    .wrAddr_ff(wrAddr_ff), .wrIdPage_ff(wrIdPage_ff), .wrIdLock_ff(wrIdLock_ff), .rdReq_ff(rdReq_ff));
`default_nettype wire

// [sim/sepc_spi_master.sv]
// serial bus master model, idle-low clock, sample on rising edge
`timescale 1ns/10ps
`default_nettype none
module sepc_spi_master (
    output logic linkClk,
    output logic selectN,
    output logic serIn,
    input wire logic serOut,
    input wire logic serOutEnN
);
    localparam int HALF = 80;
    // deselected and clock parked low at start
    initial begin
        linkClk = 1'b0;
        selectN = 1'b1;
        serIn = 1'b0;
    end
    // select, leaving a full clock period (this half plus the one in xfer) before the first rising edge
    task automatic open_frame();
        selectN = 1'b0;
        #(HALF);
    endtask
    // shift nbits msb first; read bits taken only while the device drives
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            serIn = tx[7 - i];
            #(HALF);
            linkClk = 1'b1;
            rx = {rx[6:0], (serOutEnN === 1'b0) ? serOut : 1'bx};
            #(HALF);
            linkClk = 1'b0;
        end
    endtask
    // deselect while the clock is low, before any further rising edge
    task automatic close_frame();
        #(HALF);
        selectN = 1'b1;
        serIn = ~serIn; // released data line must not hold its value
        #(HALF * 4);
    endtask
endmodule
`default_nettype wire

// [sim/sepc_top_bench.sv]
// self-checking testbench for the serial eeprom command block
`timescale 1ns/10ps
`default_nettype none
`include "sepc_defines.vh"
module sepc_top_bench;
    localparam int TW = 1000;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic protectN = 1'b1;
    logic [7:0] rdData = 8'h00;
    wire linkClk, selectN, serIn, serOut, serOutEnN, hwLock, wrValid, wrIdPage, wrIdLock, rdReq, rdIdPage;
    wire [7:0] status;
    wire [7:0] wrData;
    wire [14:0] wrAddr;
    wire [15:0] rdAddr;
    int errCount = 0;
    int nCompared = 0;
    int wrCnt = 0;
    int rdCnt = 0;
    int n;
    logic [14:0] lastAddr = 15'h0;
    logic [7:0] lastData = 8'h00;
    logic [7:0] rx;
    logic [15:0] a;
    logic [14:0] lo [1:3] = '{15'h6000, 15'h4000, 15'h0000};
    // ****************************************
    // instances, clock and array stand-in
    // ****************************************
    sepc_spi_master master (.linkClk(linkClk), .selectN(selectN), .serIn(serIn), .serOut(serOut),
        .serOutEnN(serOutEnN));
    sepc_top #(.TW_CYCLES(TW), .FIFO_DEPTH(8)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .linkClk(linkClk),
        .selectN(selectN), .serIn(serIn), .protectN(protectN), .serOut_ff(serOut), .serOutEnN_ff(serOutEnN),
        .statusByte_ff(status), .hardwareLockedMode_ff(hwLock), .wrValid_ff(wrValid), .wrAddr_ff(wrAddr),
        .wrData_ff(wrData), .wrIdPage_ff(wrIdPage), .wrIdLock_ff(wrIdLock), .wrReady(1'b1), .rdReq_ff(rdReq),
        .rdAddr_ff(rdAddr), .rdIdPage_ff(rdIdPage), .rdValid(1'b0), .rdData(rdData));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // count array requests and keep the last write
    always @(posedge clk_sys) begin
        if (wrValid === 1'b1) begin
            wrCnt++;
            lastAddr = wrAddr;
            lastData = wrData;
        end
        if (rdReq === 1'b1) rdCnt++;
    end
    // array answers with a pattern made from the address
    always @(negedge clk_sys) begin
        rdData <= rdAddr[7:0] ^ 8'h5A;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b[$], input int lastBits = 8);
        logic [7:0] r;
        @(negedge clk_sys);
        master.open_frame();
        foreach (b[i]) master.xfer(b[i], (i == b.size() - 1) ? lastBits : 8, r);
        master.close_frame();
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (status[0] !== 1'b0 && k < TW + 200) begin
            @(negedge clk_sys);
            k++;
        end
        check(status[0], 16'h0);
    endtask
    task automatic set_status(input logic [7:0] v);
        cmd({`SEPC_OP_SET_LATCH});
        cmd({`SEPC_OP_STAT_WR, v});
        wait_idle();
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic sc_status_read();
        check(serOutEnN, 16'h1);
        @(negedge clk_sys);
        master.open_frame();
        master.xfer(`SEPC_OP_STAT_RD, 8, rx);
        master.xfer(8'h00, 8, rx);
        check(rx, 16'h00);
        master.xfer(8'h00, 8, rx);
        check(rx, 16'h00);
        master.close_frame();
    endtask
    task automatic sc_latch();
        cmd({`SEPC_OP_SET_LATCH});
        check(status, 16'h02);
        cmd({`SEPC_OP_CLR_LATCH});
        check(status, 16'h00);
        cmd({8'hFF, `SEPC_OP_SET_LATCH});
        check(status, 16'h00);
        n = wrCnt;
        cmd({`SEPC_OP_MEM_WR, 8'h00, 8'h10, 8'hA5});
        check(16'(wrCnt - n), 16'h0);
        check(status, 16'h00);
        cmd({`SEPC_OP_SET_LATCH});
        cmd({`SEPC_OP_MEM_WR, 8'h00, 8'h10, 8'h77}, 7);
        check(16'(wrCnt - n), 16'h0);
        check(status, 16'h02);
        cmd({`SEPC_OP_CLR_LATCH});
    endtask
    task automatic sc_status_write();
        cmd({`SEPC_OP_SET_LATCH});
        cmd({`SEPC_OP_STAT_WR, 8'h04});
        check(status[0], 16'h1);
        n = rdCnt;
        cmd({`SEPC_OP_MEM_RD, 8'h00, 8'h12});
        check(16'(rdCnt - n), 16'h0);
        @(negedge clk_sys);
        master.open_frame();
        master.xfer(`SEPC_OP_STAT_RD, 8, rx);
        master.xfer(8'h00, 8, rx);
        master.close_frame();
        check(rx[1:0], 16'h3);
        wait_idle();
        check(status, 16'h04);
    endtask
    task automatic sc_protect();
        for (int k = 1; k < 4; k++) begin
            set_status(8'(k << 2));
            cmd({`SEPC_OP_SET_LATCH});
            n = wrCnt;
            a = {1'b1, lo[k]};
            cmd({`SEPC_OP_MEM_WR, a[15:8], a[7:0], 8'h11});
            check(16'(wrCnt - n), 16'h0);
            if (k < 3) begin
                a = {1'b1, lo[k] - 15'h1};
                cmd({`SEPC_OP_MEM_WR, a[15:8], a[7:0], 8'h3C});
                wait_idle();
                check(16'(wrCnt - n), 16'h1);
                check(lastAddr, a[14:0]);
                check(lastData, 16'h3C);
            end else cmd({`SEPC_OP_CLR_LATCH});
        end
        set_status(8'h00);
        @(negedge clk_sys);
        master.open_frame();
        master.xfer(`SEPC_OP_MEM_RD, 8, rx);
        master.xfer(8'h80, 8, rx);
        master.xfer(8'h12, 8, rx);
        master.xfer(8'h00, 8, rx);
        master.close_frame();
        check(rx, 16'h48);
        check({wrIdPage, wrIdLock, rdIdPage}, 16'h0);
    endtask
    task automatic sc_hw_lock();
        set_status(8'h84);
        @(negedge clk_sys);
        protectN = 1'b0;
        repeat (10) @(negedge clk_sys);
        check(hwLock, 16'h1);
        cmd({`SEPC_OP_SET_LATCH});
        cmd({`SEPC_OP_STAT_WR, 8'h00});
        repeat (40) @(negedge clk_sys);
        check(status, 16'h86);
        protectN = 1'b1;
        repeat (10) @(negedge clk_sys);
        check(hwLock, 16'h0);
        cmd({`SEPC_OP_STAT_WR, 8'h00});
        wait_idle();
        check(status, 16'h00);
    endtask
    // main sequence
    initial begin
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk_sys);
        sc_status_read();
        sc_latch();
        sc_status_write();
        sc_protect();
        sc_hw_lock();
        closeOut();
    end
    // watchdog against a hang
    initial begin
        #900000;
        errCount++;
        closeOut();
    end
endmodule
`default_nettype wire
